// *** inc/rtsd_consts.vh ***
/*
  Constants of the supply, oscillator and battery status-detection block:
  register offsets, field positions, reset values and timing figures.
  Assumes a single 25 MHz core clock and a 4-bit register address space.
*/
// Overview of operation
// - The power-up flag goes to 1 whenever supply rises from 0 V and holds until cleared.
// - Writing 0 to the power-up flag clears it and releases the held registers; writing 1 does nothing.
// - While the power-up flag is 1, alarm, RAM, trim and control bits are held at 0.
// - A power-up event releases both interrupt pins to the off state.
// - After power-up the second control register reads 1 in bits 6, 5 and 4, else 0.
// - Read-only bits such as debounce select always read 0 and ignore writes.
// - A detected oscillator stop drives the oscillator-halt flag to 0.
// - After software writes 1 to the halt flag, a later stop clears it to 0 again.
// - A battery input below threshold sets the battery-low flag, held until cleared.
// - Writing 0 to the battery-low flag clears it and restarts monitoring; 1 is ignored.
// - The battery monitor samples only during a 7.8 ms window in each one-second period.
// - While the battery-low flag is 1, battery sampling is suspended entirely.
`ifndef RTSD_CONSTS_VH
`define RTSD_CONSTS_VH

// register offsets
`define RTSD_ADDR_RAM       4'h6
`define RTSD_ADDR_TRIM      4'h7
`define RTSD_ADDR_ALM_FIRST 4'h8
`define RTSD_ADDR_ALM_LAST  4'hc
`define RTSD_ADDR_CTRL1     4'he
`define RTSD_ADDR_CTRL2     4'hf

// first control register fields
`define RTSD_C1_WK_EN   7
`define RTSD_C1_MO_EN   6
`define RTSD_C1_DEBSEL  5
`define RTSD_C1_EDGE_EN 4

// second control register fields
`define RTSD_C2_BANK    7
`define RTSD_C2_BATLOW  6
`define RTSD_C2_OSCHLT  5
`define RTSD_C2_PWRUP   4
`define RTSD_C2_EDGE    3
`define RTSD_C2_TICK    2
`define RTSD_C2_WKHIT   1
`define RTSD_C2_MOHIT   0

// reset values
`define RTSD_C2_RESET   8'h70
`define RTSD_ZERO_BYTE  8'h00
`define RTSD_C1_RO_MASK 8'hdf

// timing
`define RTSD_CLK_HZ       25000000
`define RTSD_PERIOD_US    1000000
`define RTSD_WINDOW_US    7800
`define RTSD_PERIOD_CYC   ((`RTSD_CLK_HZ / 1000000) * `RTSD_PERIOD_US)
`define RTSD_WINDOW_CYC   ((`RTSD_CLK_HZ / 1000000) * `RTSD_WINDOW_US)
`define RTSD_SYNC_STAGES  2

`endif

// *** design/rtsd_sync.v ***
/*
  Two-stage level synchroniser for a group of detector inputs.
  Assumes the detector levels come from logic outside the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module rtsd_sync #(
  parameter WIDTH = 3
) (
  input  wire             i_core_clk,
  input  wire             i_resetn,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // rtsd_sync

`default_nettype wire

// *** design/rtsd_batt_sampler.v ***
/*
  Battery-monitor sampling timer: opens a short window once per period.
  Assumes one core clock; counts are parameters so simulation can shorten them.
*/
`timescale 1ns/1ps
`default_nettype none

module rtsd_batt_sampler #(
  parameter PERIOD_CYC = 25000000,
  parameter WINDOW_CYC = 195000,
  parameter CNT_W      = 25
) (
  input  wire i_core_clk,
  input  wire i_resetn,
  input  wire i_run,
  input  wire i_restart,
  output wire o_window
);

  localparam [CNT_W-1:0] LAST = PERIOD_CYC - 1;
  localparam [CNT_W-1:0] WIN  = WINDOW_CYC;

  reg [CNT_W-1:0] cnt_reg;
  reg             win_reg;

  // period counter, frozen while sampling is suspended
  always @(posedge i_core_clk) begin
    if (!i_resetn || i_restart) begin
      cnt_reg <= {CNT_W{1'b0}};
      win_reg <= 1'b0;
    end else if (i_run) begin
      if (cnt_reg == LAST) begin
        cnt_reg <= {CNT_W{1'b0}};
      end else begin
        cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      win_reg <= (cnt_reg < WIN); // window at the start of each period
    end else begin
      win_reg <= 1'b0; // no sampling while flag set
    end
  end

  assign o_window = win_reg & i_run;

endmodule // rtsd_batt_sampler

`default_nettype wire

// *** design/rtsd_top.v ***
/*
  Status-detection block of a clock/calendar device: power-up, oscillator
  halt and battery-low flags in the second control register, with the
  power-up initialisation of alarm, RAM, trim and control registers.
  Assumes a serial-bus front end outside that presents single-cycle read
  and write strobes with a 4-bit offset, and detector levels from analog
  circuits outside the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtsd_consts.vh"

module rtsd_top #(
  parameter PERIOD_CYC = `RTSD_PERIOD_CYC,
  parameter WINDOW_CYC = `RTSD_WINDOW_CYC,
  parameter ALM_WORDS  = 5
) (
  input  wire       i_core_clk,
  input  wire       i_resetn,
  input  wire [3:0] i_reg_addr,
  input  wire       i_reg_wr,
  input  wire       i_reg_rd,
  input  wire [7:0] i_reg_wdata,
  output wire [7:0] o_reg_rdata,
  input  wire       i_supply_rise_det,
  input  wire       i_osc_stop_det,
  input  wire       i_backup_supply_low,
  input  wire [4:0] i_event_hits,
  output wire       o_batt_sample,
  output wire       o_irq_out_a,
  output wire       o_irq_out_a_oe,
  output wire       o_irq_out_b,
  output wire       o_irq_out_b_oe
);

  // decode helper shared by the write and read paths
  function is_alarm;
    input [3:0] addr;
    begin
      is_alarm = (addr >= `RTSD_ADDR_ALM_FIRST) && (addr <= `RTSD_ADDR_ALM_LAST);
    end
  endfunction

  reg [7:0] alarm_reg [0:ALM_WORDS-1];
  reg [7:0] ram_reg;
  reg [7:0] trim_reg;
  reg [7:0] ctrl1_reg;
  reg       power_up_flag_reg;
  reg       osc_halt_flag_reg;
  reg       battery_low_flag_reg;
  reg       bank_stamp_hit_reg;
  reg       edge_event_hit_reg;
  reg       periodic_tick_hit_reg;
  reg       weekday_alarm_hit_reg;
  reg       monthday_alarm_hit_reg;
  reg [7:0] rdata_reg;
  reg       irq_a_reg;
  reg       irq_b_reg;
  reg       pwr_seen_reg;
  reg       osc_seen_reg;

  wire [2:0] det_sync;
  wire       pwr_sync;
  wire       osc_sync;
  wire       bat_sync;
  wire       pwr_event;
  wire       osc_event;
  wire       bat_window;
  wire       bat_event;
  wire       wr_ctrl2;
  wire       bat_clear;
  wire [7:0] ctrl2_view;
  wire [2:0] alm_idx;

  // detector levels cross into the core clock before use
  rtsd_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_async    ({i_backup_supply_low, i_osc_stop_det, i_supply_rise_det}),
    .o_sync     (det_sync)
  );

  assign pwr_sync = det_sync[0];
  assign osc_sync = det_sync[1];
  assign bat_sync = det_sync[2];

  // rising edges only; a held detector level is one event
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      pwr_seen_reg <= 1'b0;
      osc_seen_reg <= 1'b0;
    end else begin
      pwr_seen_reg <= pwr_sync;
      osc_seen_reg <= osc_sync;
    end
  end

  assign pwr_event = pwr_sync & ~pwr_seen_reg;
  assign osc_event = osc_sync & ~osc_seen_reg;

  assign wr_ctrl2  = i_reg_wr && (i_reg_addr == `RTSD_ADDR_CTRL2);
  // only a written 0 clears the battery flag and restarts the sampler
  assign bat_clear = wr_ctrl2 && !i_reg_wdata[`RTSD_C2_BATLOW];

  rtsd_batt_sampler #(
    .PERIOD_CYC (PERIOD_CYC),
    .WINDOW_CYC (WINDOW_CYC),
    .CNT_W      (25)
  ) u_sampler (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_run      (~battery_low_flag_reg),
    .i_restart  (bat_clear),
    .o_window   (bat_window)
  );

  // sampling stops once the flag is up
  assign bat_event     = bat_window & bat_sync & ~battery_low_flag_reg;
  assign o_batt_sample = bat_window;

  // power-up flag: event sets, software 0 clears, set wins over clear
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      power_up_flag_reg <= 1'b1;
    end else if (pwr_event) begin
      power_up_flag_reg <= 1'b1;
    end else if (wr_ctrl2 && !i_reg_wdata[`RTSD_C2_PWRUP]) begin
      power_up_flag_reg <= 1'b0; // writing 1 leaves it alone
    end
  end

  // oscillator-halt flag: power-up presets 1, a stop forces 0
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      osc_halt_flag_reg <= 1'b1;
    end else if (osc_event) begin
      osc_halt_flag_reg <= 1'b0; // stop wins over a same-cycle write
    end else if (pwr_event) begin
      osc_halt_flag_reg <= 1'b1;
    end else if (wr_ctrl2) begin
      osc_halt_flag_reg <= i_reg_wdata[`RTSD_C2_OSCHLT]; // re-arm by writing 1
    end
  end

  // battery-low flag: sampled drop sets, written 0 clears, set wins
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      battery_low_flag_reg <= 1'b1;
    end else if (bat_event || pwr_event) begin
      battery_low_flag_reg <= 1'b1; // and
    end else if (bat_clear) begin
      battery_low_flag_reg <= 1'b0;
    end
  end

  // remaining control-2 event bits: sticky, cleared by written 0
  always @(posedge i_core_clk) begin
    if (!i_resetn || power_up_flag_reg || pwr_event) begin
      bank_stamp_hit_reg     <= 1'b0; // held clear during power-up
      edge_event_hit_reg     <= 1'b0;
      periodic_tick_hit_reg  <= 1'b0;
      weekday_alarm_hit_reg  <= 1'b0;
      monthday_alarm_hit_reg <= 1'b0;
    end else begin
      bank_stamp_hit_reg     <= i_event_hits[4] |
                                (bank_stamp_hit_reg & ~(wr_ctrl2 & ~i_reg_wdata[`RTSD_C2_BANK]));
      edge_event_hit_reg     <= i_event_hits[3] |
                                (edge_event_hit_reg & ~(wr_ctrl2 & ~i_reg_wdata[`RTSD_C2_EDGE]));
      periodic_tick_hit_reg  <= i_event_hits[2] |
                                (periodic_tick_hit_reg & ~(wr_ctrl2 & ~i_reg_wdata[`RTSD_C2_TICK]));
      weekday_alarm_hit_reg  <= i_event_hits[1] |
                                (weekday_alarm_hit_reg & ~(wr_ctrl2 & ~i_reg_wdata[`RTSD_C2_WKHIT]));
      monthday_alarm_hit_reg <= i_event_hits[0] |
                                (monthday_alarm_hit_reg & ~(wr_ctrl2 & ~i_reg_wdata[`RTSD_C2_MOHIT]));
    end
  end

  // first alarm offset has zero low bits, so the low bits index the word directly
  assign alm_idx = i_reg_addr[2:0];

  // alarm words; writes ignored and contents cleared while power-up flag is up
  genvar g;
  generate
    for (g = 0; g < ALM_WORDS; g = g + 1) begin : g_alarm
      always @(posedge i_core_clk) begin
        if (!i_resetn || power_up_flag_reg || pwr_event) begin
          alarm_reg[g] <= `RTSD_ZERO_BYTE;
        end else if (i_reg_wr && is_alarm(i_reg_addr) && (alm_idx == g)) begin
          alarm_reg[g] <= i_reg_wdata;
        end
      end
    end
  endgenerate

  // RAM, trim and first control register
  always @(posedge i_core_clk) begin
    if (!i_resetn || power_up_flag_reg || pwr_event) begin
      ram_reg   <= `RTSD_ZERO_BYTE;
      trim_reg  <= `RTSD_ZERO_BYTE;
      ctrl1_reg <= `RTSD_ZERO_BYTE;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `RTSD_ADDR_RAM) begin
        ram_reg <= i_reg_wdata;
      end
      if (i_reg_addr == `RTSD_ADDR_TRIM) begin
        trim_reg <= i_reg_wdata;
      end
      if (i_reg_addr == `RTSD_ADDR_CTRL1) begin
        ctrl1_reg <= i_reg_wdata & `RTSD_C1_RO_MASK; // debounce select stays 0
      end
    end
  end

  assign ctrl2_view = {bank_stamp_hit_reg, battery_low_flag_reg, osc_halt_flag_reg,
                       power_up_flag_reg, edge_event_hit_reg, periodic_tick_hit_reg,
                       weekday_alarm_hit_reg, monthday_alarm_hit_reg};

  // read data captured on the read strobe; unmapped offsets read 0
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      rdata_reg <= `RTSD_ZERO_BYTE;
    end else if (i_reg_rd) begin
      if (is_alarm(i_reg_addr)) begin
        rdata_reg <= alarm_reg[alm_idx];
      end else begin
        case (i_reg_addr)
          `RTSD_ADDR_RAM:   rdata_reg <= ram_reg;
          `RTSD_ADDR_TRIM:  rdata_reg <= trim_reg;
          `RTSD_ADDR_CTRL1: rdata_reg <= ctrl1_reg;
          `RTSD_ADDR_CTRL2: rdata_reg <= ctrl2_view;
          default:          rdata_reg <= `RTSD_ZERO_BYTE;
        endcase
      end
    end
  end

  assign o_reg_rdata = rdata_reg;

  // open-drain interrupt pins pull low while an enabled hit is set; the tick hit pulls pin A without an enable
  always @(posedge i_core_clk) begin
    if (!i_resetn || pwr_event || power_up_flag_reg) begin
      irq_a_reg <= 1'b0; // released on power-up
      irq_b_reg <= 1'b0;
    end else begin
      irq_a_reg <= (monthday_alarm_hit_reg & ctrl1_reg[`RTSD_C1_MO_EN]) |
                   (edge_event_hit_reg & ctrl1_reg[`RTSD_C1_EDGE_EN]) |
                   periodic_tick_hit_reg;
      irq_b_reg <= weekday_alarm_hit_reg & ctrl1_reg[`RTSD_C1_WK_EN];
    end
  end

  // pin level is always low when driven; enable high means pulling
  assign o_irq_out_a    = 1'b0;
  assign o_irq_out_a_oe = irq_a_reg;
  assign o_irq_out_b    = 1'b0;
  assign o_irq_out_b_oe = irq_b_reg;

endmodule // rtsd_top

`default_nettype wire

// *** sim/rtsd_monitor.sv ***
/* rtsd_top checker: flag reads, interrupt release and sampling window.
   assumes only the top ports are visible; bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
module rtsd_monitor #(
  parameter WINDOW_CYC = 10
) (
  input wire logic       i_core_clk,
  input wire logic       i_resetn,
  input wire logic [3:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       i_supply_rise_det,
  input wire logic       i_osc_stop_det,
  input wire logic       i_backup_supply_low,
  input wire logic       o_batt_sample,
  input wire logic       o_irq_out_a_oe,
  input wire logic       o_irq_out_b_oe
);
  logic [31:0] hi_reg;
  // cycles the window has been open so far
  always @(posedge i_core_clk) begin
    if (!i_resetn || !o_batt_sample) begin
      hi_reg <= 32'h0;
    end else begin
      hi_reg <= hi_reg + 32'h1;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // writes are excluded while a detection settles, so a read shows hardware alone
  AST_PWRUP_READ: assert property (
    $rose(i_supply_rise_det) ##0 (!i_reg_wr)[*6] ##0 (i_reg_rd && i_reg_addr == 4'hf)
    |=> o_reg_rdata == 8'h70) else $error("status not 70 after power-up");
  AST_PWRUP_TRIM: assert property (
    $rose(i_supply_rise_det) ##0 (!i_reg_wr)[*8] ##0 (i_reg_rd && i_reg_addr == 4'h7)
    |=> o_reg_rdata == 8'h00) else $error("trim not cleared by power-up");
  AST_PWRUP_IRQ: assert property (
    $rose(i_supply_rise_det) |-> ##5 (!o_irq_out_a_oe && !o_irq_out_b_oe)[*2])
    else $error("interrupt pin still driven after power-up");
  AST_RO_BIT: assert property (
    i_reg_rd && i_reg_addr == 4'he |=> !o_reg_rdata[5]) else $error("read-only bit set");
  AST_OSC_STOP: assert property (
    $rose(i_osc_stop_det) ##0 (!i_reg_wr)[*6] ##0 (i_reg_rd && i_reg_addr == 4'hf)
    |=> !o_reg_rdata[5]) else $error("halt flag not cleared by stop");
  AST_OSC_REARM: assert property (
    (!i_osc_stop_det)[*4] ##0 (i_reg_wr && i_reg_addr == 4'hf && i_reg_wdata[5])
    ##1 !(i_osc_stop_det || i_reg_wr) ##1 (i_reg_rd && i_reg_addr == 4'hf && !i_reg_wr)
    |=> o_reg_rdata[5]) else $error("halt flag not stored");
  AST_WINDOW_LEN: assert property (
    o_batt_sample |-> hi_reg < WINDOW_CYC) else $error("sampling window too long");
  AST_BATT_FREEZE: assert property (
    o_batt_sample && i_backup_supply_low |-> ##[1:6] (!o_batt_sample)[*8])
    else $error("sampling went on after low battery");
  AST_RDATA_HOLD: assert property (
    !$past(i_reg_rd) |-> $stable(o_reg_rdata)) else $error("read data moved without a read");
  cover property ($rose(i_supply_rise_det));
  cover property ($rose(i_osc_stop_det));
  cover property ($rose(o_batt_sample));
endmodule // rtsd_monitor
bind rtsd_top rtsd_monitor #(.WINDOW_CYC(WINDOW_CYC)) u_mon (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_supply_rise_det(i_supply_rise_det),
  .i_osc_stop_det(i_osc_stop_det), .i_backup_supply_low(i_backup_supply_low),
  .o_batt_sample(o_batt_sample), .o_irq_out_a_oe(o_irq_out_a_oe),
  .o_irq_out_b_oe(o_irq_out_b_oe));
`default_nettype wire

// *** sim/rtsd_host.sv ***
/* host controller model: one-cycle register strobes at falling edges.
   assumes the bench calls its tasks; gap adds idle cycles before each. */
`timescale 1ns/1ps
`default_nettype none
module rtsd_host (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_rdata,
  output var  logic [3:0] o_addr,
  output var  logic       o_wr,
  output var  logic       o_rd,
  output var  logic [7:0] o_wdata
);
  int gap = 0;
  // bus idle at time zero
  initial begin
    o_addr = 4'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // flags are cleared by writing 0; a 1 on the halt bit re-arms it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    repeat (gap) @(negedge i_core_clk);
    @(negedge i_core_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_core_clk);
    o_wr = 1'b0;
    o_wdata = ~d; // stale data never looks valid
  endtask
  // data is taken one falling edge after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    repeat (gap) @(negedge i_core_clk);
    @(negedge i_core_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_core_clk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
endmodule // rtsd_host
`default_nettype wire

// *** sim/rtsd_top_tb.sv ***
/* self-checking bench for rtsd_top with a 100-cycle sampling period.
   assumes the host model drives all register strobes. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("FAIL t=%0t got %0h exp %0h", $time, g, e); end end
module rtsd_top_tb;
  localparam int WIN = 10;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        sup = 1'b0;
  logic        osc = 1'b0;
  logic        backup_supply_in = 1'b0;
  logic [4:0]  hits = 5'h00;
  logic [3:0]  addr;
  logic        wr, rd, samp, oea, oeb, pa, pb;
  logic [7:0]  wdata, rdata, v, w;
  logic [31:0] seed = 32'h6816;
  int          errors = 0, n_compared = 0, cyc = 0, hi;
  always #20 clk = ~clk;
  // hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      end_of_test();
    end
  end
  rtsd_top #(.PERIOD_CYC(100), .WINDOW_CYC(WIN), .ALM_WORDS(5)) dut (
    .i_core_clk(clk), .i_resetn(resetn), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_supply_rise_det(sup),
    .i_osc_stop_det(osc), .i_backup_supply_low(backup_supply_in), .i_event_hits(hits),
    .o_batt_sample(samp), .o_irq_out_a(pa), .o_irq_out_a_oe(oea), .o_irq_out_b(pb),
    .o_irq_out_b_oe(oeb));
  rtsd_host host (.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wdata));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // status byte from the three flags: battery, halt, power-up
  function automatic logic [7:0] c2(input logic b, input logic o, input logic p);
    return {1'b0, b, o, p, 4'h0};
  endfunction
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    host.rd(a, v);
    `CHK(v, e)
  endtask
  // detector rises at a falling edge; status is read five cycles later
  task automatic rise(ref logic s);
    s = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic count_hi(input int n);
    hi = 0;
    repeat (n) begin
      @(negedge clk);
      hi += int'(samp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    chk_rd(4'hf, c2(1, 1, 1));
    host.wr(4'h7, 8'h3c);
    chk_rd(4'h7, 8'h00);
    host.wr(4'hf, 8'h50);
    chk_rd(4'hf, c2(1, 0, 1));
    host.wr(4'hf, 8'h20);
    chk_rd(4'hf, c2(0, 1, 0));
    host.wr(4'hf, 8'h70);
    chk_rd(4'hf, c2(0, 1, 0));
    rise(osc);
    chk_rd(4'hf, c2(0, 0, 0));
    // random bytes into writable and read-only positions, with random spacing
    repeat (8) begin
      w = rnd();
      host.gap = rnd() % 3;
      host.wr(4'he, w);
      chk_rd(4'he, w & 8'hdf);
      host.wr(4'h7, w);
      chk_rd(4'h7, w);
    end
    host.gap = 0;
    host.wr(4'h7, 8'h5a);
    host.wr(4'he, 8'h80);
    hits = 5'h02;
    @(negedge clk);
    hits = 5'h00;
    repeat (2) @(negedge clk);
    `CHK(oeb, 1'b1)
    `CHK(oea, 1'b0)
    `CHK({pa, pb}, 2'b00)
    rise(sup);
    chk_rd(4'hf, c2(1, 1, 1));
    chk_rd(4'h7, 8'h00);
    `CHK(oeb, 1'b0)
    chk_rd(4'he, 8'h00);
    host.wr(4'hf, 8'h00);
    backup_supply_in = 1'b1;
    repeat (120) @(negedge clk);
    chk_rd(4'hf, c2(1, 0, 0));
    count_hi(250);
    `CHK(hi, 0)
    backup_supply_in = 1'b0;
    host.wr(4'hf, 8'h00);
    chk_rd(4'hf, c2(0, 0, 0));
    count_hi(200);
    `CHK(hi, 2 * WIN)
    end_of_test();
  end
endmodule // rtsd_top_tb
`default_nettype wire
